// [src/pmrd_defs.svh]
// Constants of the power mode sequencer: offsets, fields, resets, timing
// Assumes inclusion by its bare name from the src files
`ifndef PMRD_DEFS_SVH
`define PMRD_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define PMRD_OFS_STATUS 8'h00
`define PMRD_OFS_MASK   8'h04
`define PMRD_OFS_CTRL   8'h08
`define PMRD_OFS_LPTHR  8'h0C
`define PMRD_OFS_CFG2   8'h10
`define PMRD_OFS_MODE   8'h14
// ****************************************
// Status and mask fields
// ****************************************
`define PMRD_BIT_MAV    0
`define PMRD_BIT_CHG    1
`define PMRD_BIT_DONE   15
`define PMRD_LINE1_BITS 16'h8001
`define PMRD_LINE0_BITS 16'h0002
`define PMRD_UNMASKED   16'h8000
// ****************************************
// Reset values
// ****************************************
`define PMRD_RST_MASK   16'hFFFF
`define PMRD_RST_CTRL   16'h0000
`define PMRD_RST_LPTHR  8'h07
`define PMRD_RST_CFG2   8'h00
// ****************************************
// Timing
// ****************************************
`define PMRD_CLK_KHZ    25000
`define PMRD_TRANS_NS   1000
`define PMRD_STABLE_NS  320
`define PMRD_TRANS_CYC  ((`PMRD_TRANS_NS * `PMRD_CLK_KHZ + 999999) / 1000000)
`define PMRD_STABLE_CYC ((`PMRD_STABLE_NS * `PMRD_CLK_KHZ + 999999) / 1000000)
`endif

// [src/pmrd_pkg.sv]
// Types of the power mode sequencer
// Assumes nothing beyond a SystemVerilog compiler
package pmrd_pkg;
    // Pin code {mode_select_hi, mode_select_lo}
    typedef enum logic [1:0] {
        PMRD_REDUCED = 2'b00,
        PMRD_NORMAL  = 2'b01,
        PMRD_LOW     = 2'b10,
        PMRD_SLEEP   = 2'b11
    } pmrd_mode_t;

    typedef enum logic [2:0] {
        PMRD_ST_NORMAL  = 3'b000,
        PMRD_ST_TRANS   = 3'b001,
        PMRD_ST_REDUCED = 3'b010,
        PMRD_ST_LOW     = 3'b011,
        PMRD_ST_SLEEP   = 3'b100
    } pmrd_state_t;

    // Mode pins; a drv bit low means the pin is left to its pull-up
    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_hi_drv;
        logic mode_select_lo;
        logic mode_select_lo_drv;
    } pmrd_pins_t;
endpackage

// [src/pmrd_pin_sync.sv]
// Pull-up resolution, three-flop sync and stability filter of mode pins
// Assumes pins asynchronous to clk
`timescale 1ns/1ns
module pmrd_pin_sync #(
    parameter int         W      = 2,
    parameter int         STABLE = 8,
    parameter logic [1:0] INIT   = 2'h1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Pads
    input  wire logic [W-1:0] pad_lvl,
    input  wire logic [W-1:0] pad_drv,
    // Filtered code
    output logic      [W-1:0] code_q,
    output logic              chg_q
);
    localparam int CW = $clog2(STABLE + 1);
    if (STABLE < 2 || W != 2) begin : g_chk
        $error("pmrd_pin_sync: unsupported parameters");
    end

    logic [W-1:0]  pad;
    logic [W-1:0]  ff1_q, ff2_q, ff3_q, cand_q, cand_d, code_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          chg_d;

    // RULE2 pull-up resolution
    for (genvar i = 0; i < W; i++) begin : g_pad
        assign pad[i] = pad_drv[i] ? pad_lvl[i] : 1'b1;
    end

    // RULE12 stable sampling
    always_comb begin
        cand_d = cand_q;
        cnt_d  = cnt_q;
        code_d = code_q;
        chg_d  = 1'b0;
        if (ff2_q == ff3_q) begin
            if (ff3_q != cand_q) begin
                cand_d = ff3_q;
                cnt_d  = '0;
            end else if (cnt_q != CW'(STABLE - 1)) begin
                cnt_d = cnt_q + CW'(1);
            end else if (cand_q != code_q) begin
                code_d = cand_q;
                chg_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ff1_q  <= '1;
            ff2_q  <= '1;
            ff3_q  <= '1;
            cand_q <= INIT;
            cnt_q  <= '0;
            code_q <= INIT;
            chg_q  <= 1'b0;
        end else begin
            ff1_q  <= pad;
            ff2_q  <= ff1_q;
            ff3_q  <= ff2_q;
            cand_q <= cand_d;
            cnt_q  <= cnt_d;
            code_q <= code_d;
            chg_q  <= chg_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pullup_idle: assert property ((!pad_drv[0]) [*3] |=> ff2_q[0]) // RULE2
        else $error("undriven pin not read high");
    a_stable_accept: assert property (chg_q |-> $past(cnt_q) == CW'(STABLE - 1)) // RULE12
        else $error("code accepted before stable");
endmodule // pmrd_pin_sync

// [src/pmrd_irq.sv]
// Sticky status with write-one-to-clear, mask and two active-low lines
// Assumes set, clear and mask from logic on clk
`timescale 1ns/1ns
module pmrd_irq #(
    parameter int            W       = 16,
    parameter logic [W-1:0]  UNMASK  = '0,
    parameter logic [W-1:0]  LINE0   = '0,
    parameter logic [W-1:0]  LINE1   = '1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Events and clears
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] hwclr,
    input  wire logic [W-1:0] w1c,
    input  wire logic [W-1:0] mask,
    // State and lines
    output logic      [W-1:0] status_q,
    output logic              line0_b_q,
    output logic              line1_b_q
);
    logic [W-1:0] status_d, act;
    logic         line0_b_d, line1_b_d;

    // RULE8 set wins over clear
    always_comb begin
        status_d  = (status_q & ~w1c & ~hwclr) | set;
        // RULE9 unmaskable bits
        act       = status_q & (mask | UNMASK);
        // RULE10 active low lines
        line0_b_d = ~|(act & LINE0);
        line1_b_d = ~|(act & LINE1);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q  <= '0;
            line0_b_q <= 1'b1;
            line1_b_q <= 1'b1;
        end else begin
            status_q  <= status_d;
            line0_b_q <= line0_b_d;
            line1_b_q <= line1_b_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_idle_high: assert property (status_q == '0 |=> line0_b_q && line1_b_q) // RULE10
        else $error("interrupt line low with no status");
endmodule // pmrd_irq

// [src/pmrd_top.sv]
// Power mode selection, register reload and reset-done report
// Assumes an APB master on clk and an external controller on the pins
//
// Notes on behaviour
// RULE1: pin code selects normal, reduced, low, sleep
// RULE2: undriven mode pins read high
// RULE3: small variant only normal and sleep
// RULE4: controller drives mode pins from its outputs
// RULE5: return to normal reloads control register defaults
// RULE6: transition end sets done flag, line low
// RULE7: done flag zero during transition
// RULE8: writing one clears flag, releases line
// RULE9: done flag ignores its mask bit
// RULE10: interrupt lines are active low
// RULE11: reduced from low or sleep raises line
// RULE12: pins synchronised, changes taken once stable
`timescale 1ns/1ns
`include "pmrd_defs.svh"
module pmrd_top #(
    parameter bit FULL_MODES = 1'b1,
    parameter int TRANS_CYC  = `PMRD_TRANS_CYC,
    parameter int STABLE_CYC = `PMRD_STABLE_CYC
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic      [31:0]         prdata,
    output logic                     pslverr,
    // Mode pins
    input  wire pmrd_pkg::pmrd_pins_t pins,
    // Interrupts, active low
    output logic                     interrupt_out_b,
    output logic                     aux_interrupt_out_b,
    // Mode report
    output logic      [1:0]          power_mode,
    output logic                     in_transition
);
    localparam int TW = $clog2(TRANS_CYC + 1);
    if (TRANS_CYC < 1 || STABLE_CYC < 2) begin : g_chk
        $error("pmrd_top: unsupported timing parameters");
    end

    // ****************************************
    // Declarations
    // ****************************************
    pmrd_pkg::pmrd_state_t state_q, state_d;
    logic [TW-1:0]         cnt_q, cnt_d;
    logic [1:0]            code;
    logic                  chg;
    logic [1:0]            mode_q, mode_d;
    logic                  trans_q, trans_d;
    logic                  mav_evt, done_evt, chg_evt, reload;
    logic [15:0]           status, set, hwclr, w1c;
    logic [15:0]           mask_q, mask_d, ctrl_q, ctrl_d;
    logic [7:0]            lpthr_q, lpthr_d, cfg2_q, cfg2_d;
    logic                  pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0]           prdata_q, prdata_d, rdata;
    logic                  hit, wr_go;

    // ****************************************
    // Pin sampling
    // ****************************************
    // RULE4 pins from controller
    pmrd_pin_sync #(
        .W      (2),
        .STABLE (STABLE_CYC),
        .INIT   (pmrd_pkg::PMRD_NORMAL)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pad_lvl ({pins.mode_select_hi, pins.mode_select_lo}),
        .pad_drv ({pins.mode_select_hi_drv, pins.mode_select_lo_drv}),
        .code_q  (code),
        .chg_q   (chg)
    );

    // ****************************************
    // Mode state machine
    // ****************************************
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        mav_evt  = 1'b0;
        done_evt = 1'b0;
        chg_evt  = 1'b0;
        reload   = 1'b0;
        if (chg) begin
            // RULE1 pin code decode
            unique case (pmrd_pkg::pmrd_mode_t'(code))
                pmrd_pkg::PMRD_NORMAL: begin
                    if (state_q != pmrd_pkg::PMRD_ST_NORMAL &&
                        state_q != pmrd_pkg::PMRD_ST_TRANS) begin
                        // RULE5 reload on return
                        state_d = pmrd_pkg::PMRD_ST_TRANS;
                        cnt_d   = '0;
                        reload  = 1'b1;
                        chg_evt = 1'b1;
                    end
                end
                pmrd_pkg::PMRD_REDUCED: begin
                    // RULE3 full variant only
                    if (FULL_MODES) begin
                        state_d = pmrd_pkg::PMRD_ST_REDUCED;
                        chg_evt = 1'b1;
                        // RULE11 start marked unless from normal
                        mav_evt = (state_q != pmrd_pkg::PMRD_ST_NORMAL);
                    end
                end
                pmrd_pkg::PMRD_LOW: begin
                    // RULE3 full variant only
                    if (FULL_MODES) begin
                        state_d = pmrd_pkg::PMRD_ST_LOW;
                        chg_evt = 1'b1;
                    end
                end
                pmrd_pkg::PMRD_SLEEP: begin
                    state_d = pmrd_pkg::PMRD_ST_SLEEP;
                    chg_evt = 1'b1;
                end
            endcase
        end else if (state_q == pmrd_pkg::PMRD_ST_TRANS) begin
            if (cnt_q == TW'(TRANS_CYC - 1)) begin
                // RULE6 transition finished
                state_d  = pmrd_pkg::PMRD_ST_NORMAL;
                done_evt = 1'b1;
            end else begin
                cnt_d = cnt_q + TW'(1);
            end
        end
    end

    always_comb begin
        trans_d = (state_d == pmrd_pkg::PMRD_ST_TRANS);
        unique case (state_d)
            pmrd_pkg::PMRD_ST_REDUCED: mode_d = pmrd_pkg::PMRD_REDUCED;
            pmrd_pkg::PMRD_ST_LOW:     mode_d = pmrd_pkg::PMRD_LOW;
            pmrd_pkg::PMRD_ST_SLEEP:   mode_d = pmrd_pkg::PMRD_SLEEP;
            default:                   mode_d = pmrd_pkg::PMRD_NORMAL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= pmrd_pkg::PMRD_ST_NORMAL;
            cnt_q   <= '0;
            mode_q  <= pmrd_pkg::PMRD_NORMAL;
            trans_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            mode_q  <= mode_d;
            trans_q <= trans_d;
        end
    end

    // ****************************************
    // Status and interrupts
    // ****************************************
    always_comb begin
        set   = '0;
        hwclr = '0;
        w1c   = '0;
        set[`PMRD_BIT_MAV]  = mav_evt;
        set[`PMRD_BIT_CHG]  = chg_evt;
        set[`PMRD_BIT_DONE] = done_evt;
        // RULE7 flag held low in transition
        hwclr[`PMRD_BIT_DONE] = (state_q == pmrd_pkg::PMRD_ST_TRANS) || reload;
        // RULE8 write one to clear
        if (wr_go && paddr == `PMRD_OFS_STATUS) begin
            w1c = pwdata[15:0];
        end
    end

    // RULE9 done bit bypasses mask
    pmrd_irq #(
        .W      (16),
        .UNMASK (`PMRD_UNMASKED),
        .LINE0  (`PMRD_LINE0_BITS),
        .LINE1  (`PMRD_LINE1_BITS)
    ) u_irq (
        .clk       (clk),
        .rst_n     (rst_n),
        .set       (set),
        .hwclr     (hwclr),
        .w1c       (w1c),
        .mask      (mask_q),
        .status_q  (status),
        .line0_b_q (aux_interrupt_out_b),
        .line1_b_q (interrupt_out_b)
    );

    // ****************************************
    // Registers
    // ****************************************
    assign wr_go = psel && penable && pready_q && pwrite;

    always_comb begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        lpthr_d = lpthr_q;
        cfg2_d  = cfg2_q;
        if (wr_go) begin
            unique case (paddr)
                `PMRD_OFS_MASK:  mask_d  = pwdata[15:0];
                `PMRD_OFS_CTRL:  ctrl_d  = pwdata[15:0];
                `PMRD_OFS_LPTHR: lpthr_d = pwdata[7:0];
                `PMRD_OFS_CFG2:  cfg2_d  = pwdata[7:0];
                default: ;
            endcase
        end
        // RULE5 defaults, threshold and cfg2 kept
        if (reload) begin
            ctrl_d = `PMRD_RST_CTRL;
            mask_d = `PMRD_RST_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q  <= `PMRD_RST_CTRL;
            mask_q  <= `PMRD_RST_MASK;
            lpthr_q <= `PMRD_RST_LPTHR;
            cfg2_q  <= `PMRD_RST_CFG2;
        end else begin
            ctrl_q  <= ctrl_d;
            mask_q  <= mask_d;
            lpthr_q <= lpthr_d;
            cfg2_q  <= cfg2_d;
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    always_comb begin
        hit   = 1'b1;
        rdata = '0;
        unique case (paddr)
            `PMRD_OFS_STATUS: rdata[15:0] = status;
            `PMRD_OFS_MASK:   rdata[15:0] = mask_q;
            `PMRD_OFS_CTRL:   rdata[15:0] = ctrl_q;
            `PMRD_OFS_LPTHR:  rdata[7:0]  = lpthr_q;
            `PMRD_OFS_CFG2:   rdata[7:0]  = cfg2_q;
            `PMRD_OFS_MODE:   rdata[3:0]  = {FULL_MODES, trans_q, mode_q};
            default:          hit         = 1'b0;
        endcase
        pready_d  = psel && penable && !pready_q;
        prdata_d  = '0;
        pslverr_d = 1'b0;
        if (pready_d) begin
            prdata_d  = pwrite ? 32'h0000_0000 : rdata;
            pslverr_d = !hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign pready        = pready_q;
    assign prdata        = prdata_q;
    assign pslverr       = pslverr_q;
    assign power_mode    = mode_q;
    assign in_transition = trans_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_done_report;
        status[`PMRD_BIT_DONE] ##1 !interrupt_out_b;
    endsequence

    a_sleep_decode: assert property ( // RULE1
        chg && code == pmrd_pkg::PMRD_SLEEP |=> state_q == pmrd_pkg::PMRD_ST_SLEEP)
        else $error("sleep code not obeyed");
    a_small_variant: assert property ( // RULE3
        !FULL_MODES |-> state_q != pmrd_pkg::PMRD_ST_REDUCED && state_q != pmrd_pkg::PMRD_ST_LOW)
        else $error("small variant left normal and sleep");
    a_trans_reload: assert property ( // RULE5
        $rose(trans_q) |-> ctrl_q == `PMRD_RST_CTRL && mask_q == `PMRD_RST_MASK)
        else $error("control registers not reloaded");
    a_thr_kept: assert property ( // RULE5
        $rose(trans_q) && !$past(wr_go) |-> lpthr_q == $past(lpthr_q) && cfg2_q == $past(cfg2_q))
        else $error("exempt registers changed on reload");
    a_done_report: assert property (done_evt |=> s_done_report) // RULE6
        else $error("transition end not reported");
    a_flag_low: assert property (trans_q |-> !status[`PMRD_BIT_DONE]) // RULE7
        else $error("done flag set during transition");
    a_done_clear: assert property ( // RULE8
        wr_go && paddr == `PMRD_OFS_STATUS && pwdata[15] && !done_evt |=> !status[`PMRD_BIT_DONE])
        else $error("done flag not cleared");
    a_done_unmasked: assert property (status[`PMRD_BIT_DONE] |=> !interrupt_out_b) // RULE9
        else $error("done flag masked");
    a_mav_start: assert property ( // RULE11
        state_q == pmrd_pkg::PMRD_ST_REDUCED && $past(state_q) != pmrd_pkg::PMRD_ST_REDUCED
        && $past(state_q) != pmrd_pkg::PMRD_ST_NORMAL |-> status[`PMRD_BIT_MAV])
        else $error("reduced entry not marked");
    a_trans_len: assert property ( // RULE6
        $rose(trans_q) ##1 (trans_q && !chg) [*2] |-> cnt_q != '0 || TRANS_CYC < 3)
        else $error("transition counter stuck");
    a_normal_decode: assert property ( // RULE1
        chg && code == pmrd_pkg::PMRD_NORMAL && !trans_q && state_q != pmrd_pkg::PMRD_ST_NORMAL
        |=> trans_q && power_mode == pmrd_pkg::PMRD_NORMAL)
        else $error("normal code not obeyed");
    a_reduced_decode: assert property ( // RULE1
        chg && code == pmrd_pkg::PMRD_REDUCED && FULL_MODES |=> power_mode == pmrd_pkg::PMRD_REDUCED)
        else $error("reduced code not obeyed");
    a_low_decode: assert property ( // RULE1
        chg && code == pmrd_pkg::PMRD_LOW && FULL_MODES |=> power_mode == pmrd_pkg::PMRD_LOW)
        else $error("low code not obeyed");
    a_small_ignores: assert property ( // RULE3
        chg && !code[0] && !FULL_MODES |=> state_q == $past(state_q))
        else $error("small variant took a wide mode");
    a_trans_end: assert property ( // RULE6
        trans_q && !chg && cnt_q == TW'(TRANS_CYC - 1) |=> !trans_q && status[`PMRD_BIT_DONE])
        else $error("transition end missed");
    a_done_rise: assert property ( // RULE7
        $rose(status[`PMRD_BIT_DONE]) |-> $past(trans_q) && !trans_q)
        else $error("done flag rose outside transition end");
    a_line_release: assert property ( // RULE8
        $fell(status[`PMRD_BIT_DONE]) && !status[`PMRD_BIT_MAV] |=> interrupt_out_b)
        else $error("line not released after clear");
    a_aux_low: assert property ( // RULE10
        !aux_interrupt_out_b |-> $past(status[`PMRD_BIT_CHG] && mask_q[`PMRD_BIT_CHG]))
        else $error("aux line low with no unmasked change");
endmodule // pmrd_top

// [verif/pmrd_host_model.sv]
// Model of the external controller that drives the two mode pins
// Assumes the bench calls drive_code from its own process on clk
`timescale 1ns/1ns
module pmrd_host_model (
    // Clock
    input  wire logic            clk,
    // Mode pins
    output pmrd_pkg::pmrd_pins_t pins
);
    logic [1:0] code_q;
    logic       drv_q;

    initial begin
        code_q = 2'h1;
        drv_q  = 1'b1;
    end

    task automatic drive_code(input logic [1:0] c, input logic d);
        @(posedge clk);
        code_q <= c;
        drv_q  <= d;
    endtask

    assign pins = {drv_q ? code_q[1] : 1'b1, drv_q, drv_q ? code_q[0] : 1'b1, drv_q};
endmodule // pmrd_host_model

// [verif/pmrd_top_tb.sv]
// Self-checking bench of the power mode sequencer
// Assumes the sequencer top, its package and the controller model
`timescale 1ns/1ns
`include "pmrd_defs.svh"
module pmrd_top_tb;
    logic                 clk;
    logic                 rst_n;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    pmrd_pkg::pmrd_pins_t pins;
    logic                 interrupt_out_b;
    logic                 aux_interrupt_out_b;
    logic [1:0]           power_mode;
    logic                 in_transition;
    logic [1:0]           small_mode;
    logic [31:0]          rd;
    logic                 err;
    int                   failures;
    int                   comparisons;

    pmrd_top #(.FULL_MODES(1'b1), .TRANS_CYC(20), .STABLE_CYC(2)) pmrd_top_i (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pins(pins), .interrupt_out_b(interrupt_out_b), .aux_interrupt_out_b(aux_interrupt_out_b),
        .power_mode(power_mode), .in_transition(in_transition));

    pmrd_top #(.FULL_MODES(1'b0), .STABLE_CYC(2)) pmrd_top_small_i (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(), .pslverr(),
        .pins(pins), .interrupt_out_b(), .aux_interrupt_out_b(),
        .power_mode(small_mode), .in_transition());

    pmrd_host_model pmrd_host_model_i (.clk(clk), .pins(pins));

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test();
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask

    task automatic wait_for(input int sel, input logic [1:0] v);
        logic [1:0] s;
        for (int n = 0; n < 200; n++) begin
            s = sel == 0 ? power_mode : (sel == 1 ? {1'b0, interrupt_out_b} : {1'b0, in_transition});
            if (s === v) break;
            @(posedge clk);
        end
        if (s !== v) begin
            failures++;
            $display("BAD t=%0t wait seen=%h exp=%h", $time, s, v);
        end
    endtask

    task automatic go(input logic [1:0] c);
        pmrd_host_model_i.drive_code(c, 1'b1);
        wait_for(0, c);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdm(`PMRD_OFS_MASK, 32'hFFFFFFFF, 32'h0000FFFF); // mask default
        rdm(`PMRD_OFS_LPTHR, 32'hFFFFFFFF, 32'h00000007); // threshold default
        rdm(`PMRD_OFS_STATUS, 32'hFFFFFFFF, 32'h00000000); // no event yet
        rdm(`PMRD_OFS_MODE, 32'hFFFFFFFF, 32'h00000009); // normal after reset
        chk(32'(interrupt_out_b), 32'h1); // line rests high
        chk(32'(aux_interrupt_out_b), 32'h1); // aux line rests high
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `PMRD_OFS_CTRL, 32'h1234);
        apb(1'b1, `PMRD_OFS_LPTHR, 32'h5A);
        apb(1'b1, `PMRD_OFS_CFG2, 32'h3C);
        apb(1'b1, `PMRD_OFS_MASK, 32'h0);
        rdm(`PMRD_OFS_CTRL, 32'hFFFFFFFF, 32'h00001234);
        // Released pins pull up to sleep
        pmrd_host_model_i.drive_code(2'h0, 1'b0);
        wait_for(0, 2'h3);
        chk(32'(power_mode), 32'h3); // undriven pins read high
        chk(32'(small_mode), 32'h3); // sleep on small variant
        // Return to normal
        pmrd_host_model_i.drive_code(2'h1, 1'b1);
        wait_for(2, 2'h1);
        rdm(`PMRD_OFS_STATUS, 32'h8000, 32'h0); // flag low in transition
        wait_for(2, 2'h0);
        wait_for(1, 2'h0);
        chk(32'(interrupt_out_b), 32'h0); // line driven low
        chk(32'(aux_interrupt_out_b), 32'h0); // aux line low on change
        rdm(`PMRD_OFS_STATUS, 32'h8000, 32'h8000); // flag set at end
        rdm(`PMRD_OFS_CTRL, 32'hFFFFFFFF, 32'h0); // control reloaded
        rdm(`PMRD_OFS_MASK, 32'hFFFFFFFF, 32'h0000FFFF); // mask reloaded
        rdm(`PMRD_OFS_LPTHR, 32'hFFFFFFFF, 32'h0000005A); // threshold kept
        rdm(`PMRD_OFS_CFG2, 32'hFFFFFFFF, 32'h0000003C); // config 2 kept
        // Mask has no hold on the flag
        apb(1'b1, `PMRD_OFS_MASK, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(interrupt_out_b), 32'h0); // unmaskable flag
        apb(1'b1, `PMRD_OFS_STATUS, 32'h8000);
        wait_for(1, 2'h1);
        chk(32'(interrupt_out_b), 32'h1); // line released
        rdm(`PMRD_OFS_STATUS, 32'h8000, 32'h0); // flag cleared
        // Reduced from sleep, then low
        apb(1'b1, `PMRD_OFS_MASK, 32'hFFFF);
        go(2'h3);
        apb(1'b1, `PMRD_OFS_STATUS, 32'hFFFF);
        go(2'h0);
        chk(32'(power_mode), 32'h0); // reduced code
        chk(32'(small_mode), 32'h3); // small keeps sleep
        rdm(`PMRD_OFS_STATUS, 32'h1, 32'h1); // start marked
        wait_for(1, 2'h0);
        chk(32'(interrupt_out_b), 32'h0); // line low
        go(2'h2);
        chk(32'(power_mode), 32'h2); // low code
        chk(32'(small_mode), 32'h3); // small keeps sleep
        // Reduced from normal
        pmrd_host_model_i.drive_code(2'h1, 1'b1);
        wait_for(2, 2'h1);
        wait_for(2, 2'h0);
        wait_for(1, 2'h0);
        apb(1'b1, `PMRD_OFS_STATUS, 32'hFFFF);
        repeat (2) @(posedge clk);
        chk(32'(interrupt_out_b), 32'h1); // line released
        go(2'h0);
        rdm(`PMRD_OFS_STATUS, 32'h1, 32'h0); // no mark from normal
        chk(32'(small_mode), 32'h1); // small ignores reduced
        // Two-cycle glitch is filtered
        apb(1'b1, `PMRD_OFS_STATUS, 32'hFFFF);
        pmrd_host_model_i.drive_code(2'h3, 1'b1);
        @(posedge clk);
        pmrd_host_model_i.drive_code(2'h0, 1'b1);
        repeat (20) @(posedge clk);
        chk(32'(power_mode), 32'h0); // glitch ignored
        rdm(`PMRD_OFS_STATUS, 32'h3, 32'h0); // no mode change seen
        end_of_test();
    end
endmodule // pmrd_top_tb
